// ### core/dopp_pkg.sv
// Shared constants, register map and types of the output power protection block.
package dopp_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NPATH = 2;
   localparam int unsigned SAMP_W = 16;
   localparam int unsigned MSB_KEEP = 6;
   localparam int unsigned PWR_W = 12;
   localparam int unsigned RES_W = 13;
   localparam int unsigned SHORT_DEPTH = 8;
   localparam int unsigned LONG_CNT_W = 24;
   localparam int unsigned LONG_ACC_W = 36;
   localparam int unsigned NFLAG = 4;
   // Register offsets.
   localparam logic [11:0] OFF_PAGE = 12'h008;
   localparam logic [11:0] OFF_MAIN_INTERP = 12'h110;
   localparam logic [11:0] OFF_LONG_LIM_LO = 12'h583;
   localparam logic [11:0] OFF_LONG_LIM_HI = 12'h584;
   localparam logic [11:0] OFF_LONG_EXP = 12'h585;
   localparam logic [11:0] OFF_LONG_RES_LO = 12'h586;
   localparam logic [11:0] OFF_LONG_RES_HI = 12'h587;
   localparam logic [11:0] OFF_SHORT_LIM_LO = 12'h588;
   localparam logic [11:0] OFF_SHORT_LIM_HI = 12'h589;
   localparam logic [11:0] OFF_SHORT_EXP = 12'h58a;
   localparam logic [11:0] OFF_SHORT_RES_LO = 12'h58b;
   localparam logic [11:0] OFF_SHORT_RES_HI = 12'h58c;
   localparam logic [11:0] OFF_PROT_CTRL = 12'h590;
   localparam logic [11:0] OFF_IRQ_CFG = 12'h591;
   localparam logic [11:0] OFF_FLAGS = 12'h592;
   // Field positions.
   localparam int unsigned PAGE_LSB = 6;
   localparam int unsigned LONG_EXP_BIAS = 9;
   localparam int unsigned CTRL_PWR_RAMP = 0;
   localparam int unsigned CTRL_LINK_RAMP = 1;
   localparam int unsigned CTRL_SW_TRIG = 2;
   localparam int unsigned CTRL_SW_TXEN = 3;
   localparam int unsigned FLAG_PWR = 0;
   localparam int unsigned FLAG_LINK = 1;
   localparam int unsigned FLAG_SW = 2;
   localparam int unsigned FLAG_BLANK = 3;
   localparam int unsigned IRQ_ROUTE_LSB = 4;
   // Reset values.
   localparam logic [7:0] PAGE_RST = 8'hc0;
   localparam logic [7:0] INTERP_RST = 8'h00;
   localparam logic [12:0] LIMIT_RST = 13'h1fff;
   localparam logic [3:0] LONG_EXP_RST = 4'h0;
   localparam logic [1:0] SHORT_EXP_RST = 2'h0;
   localparam logic [7:0] CTRL_RST = 8'h03;
   localparam logic [7:0] IRQ_RST = 8'h00;
   // Summing node: cycles per accepted sample when channel interpolation is above unity.
   localparam int unsigned SUM_RATE_DIV = 2;
   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } dopp_sample_t;
   typedef enum logic [1:0] {
      DOPP_BLANK_OFF = 2'b00,
      DOPP_BLANK_FLUSH = 2'b01,
      DOPP_BLANK_RUN = 2'b11
   } dopp_blank_t;
endpackage

// ### core/dopp_top.sv
// Per-path power detection, protection triggers, interrupt routing and sample buffering.
`timescale 1ns/1ps
module dopp_top (
   input wire logic CLK_I,
   input wire logic RST_B_I,
   input wire logic [11:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic CHAN_BYPASS_I,
   input wire dopp_pkg::dopp_sample_t [1:0] SAMPLE_I,
   input wire logic [1:0] SAMPLE_VALID_I,
   output logic [1:0] SAMPLE_READY_O,
   output dopp_pkg::dopp_sample_t [1:0] SAMPLE_O,
   output logic [1:0] SAMPLE_VALID_O,
   input wire logic [1:0] SAMPLE_READY_I,
   input wire logic [1:0] TRANSMIT_ENABLE_I,
   input wire logic [1:0] LINK_ERROR_I,
   output logic [1:0] POWER_PROTECT_O,
   output logic [1:0] RAMP_DOWN_O,
   output logic MAIN_BYPASS_O,
   output logic INTERRUPT_OUT_0_B_O,
   output logic INTERRUPT_OUT_1_B_O
);

   // Paged registers are indexed by datapath; the shared ones are single.
   logic [7:0] page;
   logic [7:0] main_interp;
   logic [12:0] long_lim [2];
   logic [12:0] short_lim [2];
   logic [3:0] long_exp [2];
   logic [1:0] short_exp [2];
   logic [12:0] long_res [2];
   logic [12:0] short_res [2];
   logic [7:0] prot_ctrl [2];
   logic [7:0] irq_cfg [2];
   logic [3:0] flags [2];
   logic [1:0] interrupt_out_0_hit;
   logic [1:0] interrupt_out_1_hit;
   logic [$clog2(dopp_pkg::SUM_RATE_DIV)-1:0] rate_cnt;
   logic rate_en;

   // Picks the path whose paged value a read returns: the lowest selected one, or path 1 when no page bit is set.
   function automatic int unsigned read_path(input logic [7:0] pg);
      read_path = pg[dopp_pkg::PAGE_LSB] ? 0 : 1;
   endfunction

   // True when a write lands on a paged register of the given path.
   function automatic logic paged_write(input logic [7:0] pg, input int unsigned p,
                                        input logic [11:0] a, input logic [11:0] off);
      paged_write = pg[dopp_pkg::PAGE_LSB + p] && (a == off);
   endfunction

   // Page mask and the shared interpolation setting.
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         page <= dopp_pkg::PAGE_RST;
         main_interp <= dopp_pkg::INTERP_RST;
      end else if (REG_WR_I) begin
         if (REG_ADDR_I == dopp_pkg::OFF_PAGE) begin
            page <= REG_WDATA_I;
         end
         if (REG_ADDR_I == dopp_pkg::OFF_MAIN_INTERP) begin
            main_interp <= REG_WDATA_I;
         end
      end
   end

   // A value of zero selects unity interpolation, which bypasses the main features.
   assign MAIN_BYPASS_O = (main_interp == 8'h00);

   // Summing node rate cap: one sample per divider period unless channels are bypassed.
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rate_cnt <= '0;
      end else if (rate_cnt == $bits(rate_cnt)'(dopp_pkg::SUM_RATE_DIV - 1)) begin
         rate_cnt <= '0;
      end else begin
         rate_cnt <= rate_cnt + 1'b1;
      end
   end
   assign rate_en = CHAN_BYPASS_I || (rate_cnt == '0);

   for (genvar p = 0; p < 2; p++) begin : g_path
      dopp_pkg::dopp_blank_t blank_state;
      dopp_pkg::dopp_blank_t next_blank_state;
      logic txen;
      logic txen_prev;
      logic sw_trig;
      logic take;
      logic [11:0] inst_pwr;
      logic signed [5:0] i_top;
      logic signed [5:0] q_top;
      logic [11:0] hist [dopp_pkg::SHORT_DEPTH];
      logic [14:0] short_sum;
      logic [23:0] long_cnt;
      logic [35:0] long_acc;
      logic [35:0] long_sum;
      logic [23:0] long_last;
      logic pwr_prot;
      logic pwr_prot_prev;
      logic blank_prot;
      logic [3:0] events;
      dopp_pkg::dopp_sample_t mem [2];
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] count;
      logic push;
      logic pop;

      // Per-path protection settings; both page bits set updates both copies alike.
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
         if (!RST_B_I) begin
            long_lim[p] <= dopp_pkg::LIMIT_RST;
            short_lim[p] <= dopp_pkg::LIMIT_RST;
            long_exp[p] <= dopp_pkg::LONG_EXP_RST;
            short_exp[p] <= dopp_pkg::SHORT_EXP_RST;
            prot_ctrl[p] <= dopp_pkg::CTRL_RST;
            irq_cfg[p] <= dopp_pkg::IRQ_RST;
         end else if (REG_WR_I) begin
            if (paged_write(page, p, REG_ADDR_I, dopp_pkg::OFF_LONG_LIM_LO)) begin
               long_lim[p][7:0] <= REG_WDATA_I;
            end
            if (paged_write(page, p, REG_ADDR_I, dopp_pkg::OFF_LONG_LIM_HI)) begin
               long_lim[p][12:8] <= REG_WDATA_I[4:0];
            end
            if (paged_write(page, p, REG_ADDR_I, dopp_pkg::OFF_SHORT_LIM_LO)) begin
               short_lim[p][7:0] <= REG_WDATA_I;
            end
            if (paged_write(page, p, REG_ADDR_I, dopp_pkg::OFF_SHORT_LIM_HI)) begin
               short_lim[p][12:8] <= REG_WDATA_I[4:0];
            end
            if (paged_write(page, p, REG_ADDR_I, dopp_pkg::OFF_LONG_EXP)) begin
               long_exp[p] <= REG_WDATA_I[3:0];
            end
            if (paged_write(page, p, REG_ADDR_I, dopp_pkg::OFF_SHORT_EXP)) begin
               short_exp[p] <= REG_WDATA_I[1:0];
            end
            if (paged_write(page, p, REG_ADDR_I, dopp_pkg::OFF_PROT_CTRL)) begin
               // The trigger bit is a strobe and never stays set.
               prot_ctrl[p] <= REG_WDATA_I & ~(8'h01 << dopp_pkg::CTRL_SW_TRIG);
            end
            if (paged_write(page, p, REG_ADDR_I, dopp_pkg::OFF_IRQ_CFG)) begin
               irq_cfg[p] <= REG_WDATA_I;
            end
         end
      end

      // Writing a one to the trigger bit fires the software protect for one cycle.
      assign sw_trig = REG_WR_I && paged_write(page, p, REG_ADDR_I, dopp_pkg::OFF_PROT_CTRL)
                       && REG_WDATA_I[dopp_pkg::CTRL_SW_TRIG];

      // Transmit enable from the pin or from software; the edge is seen on their OR, so a source rising while the other is high gives no edge.
      assign txen = TRANSMIT_ENABLE_I[p] | prot_ctrl[p][dopp_pkg::CTRL_SW_TXEN];
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
         if (!RST_B_I) begin
            txen_prev <= 1'b0;
         end else begin
            txen_prev <= txen;
         end
      end

      // Blanking sequence: a rising enable flushes the path for one cycle, then runs.
      always_comb begin
         next_blank_state = blank_state;
         case (blank_state)
            dopp_pkg::DOPP_BLANK_OFF: begin
               if (txen && !txen_prev) begin
                  next_blank_state = dopp_pkg::DOPP_BLANK_FLUSH;
               end
            end
            dopp_pkg::DOPP_BLANK_FLUSH: begin
               next_blank_state = txen ? dopp_pkg::DOPP_BLANK_RUN : dopp_pkg::DOPP_BLANK_OFF;
            end
            dopp_pkg::DOPP_BLANK_RUN: begin
               if (!txen) begin
                  next_blank_state = dopp_pkg::DOPP_BLANK_OFF;
               end
            end
            default: begin
               next_blank_state = dopp_pkg::DOPP_BLANK_OFF;
            end
         endcase
      end
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
         if (!RST_B_I) begin
            blank_state <= dopp_pkg::DOPP_BLANK_OFF;
         end else begin
            blank_state <= next_blank_state;
         end
      end
      assign blank_prot = (blank_state == dopp_pkg::DOPP_BLANK_FLUSH);

      // Instantaneous power from the six top bits of each component.
      assign take = SAMPLE_VALID_I[p] && SAMPLE_READY_O[p];
      assign i_top = SAMPLE_I[p].i[15:10];
      assign q_top = SAMPLE_I[p].q[15:10];
      assign inst_pwr = 12'(i_top * i_top) + 12'(q_top * q_top);

      // Short window: history of the last eight powers, summed over the chosen length.
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
         if (!RST_B_I) begin
            for (int k = 0; k < dopp_pkg::SHORT_DEPTH; k++) begin
               hist[k] <= '0;
            end
         end else if (take) begin
            hist[0] <= inst_pwr;
            for (int k = 1; k < dopp_pkg::SHORT_DEPTH; k++) begin
               hist[k] <= hist[k - 1];
            end
         end
      end
      always_comb begin
         short_sum = '0;
         for (int k = 0; k < dopp_pkg::SHORT_DEPTH; k++) begin
            if (k < (1 << short_exp[p])) begin
               short_sum = short_sum + 15'(hist[k]);
            end
         end
      end

      // Long window: block accumulation of two to the exponent plus nine powers.
      // Flip-flop storage of up to sixteen million samples is out of reach, so the long
      // filter reports once per window rather than sliding sample by sample.
      assign long_last = 24'((36'h1 << (long_exp[p] + dopp_pkg::LONG_EXP_BIAS)) - 36'h1);
      assign long_sum = long_acc + 36'(inst_pwr);
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
         if (!RST_B_I) begin
            long_cnt <= '0;
            long_acc <= '0;
            long_res[p] <= '0;
         end else if (take) begin
            if (long_cnt >= long_last) begin
               long_cnt <= '0;
               long_acc <= '0;
               long_res[p] <= 13'(long_sum >> (long_exp[p] + dopp_pkg::LONG_EXP_BIAS));
            end else begin
               long_cnt <= long_cnt + 1'b1;
               long_acc <= long_sum;
            end
         end
      end

      // Short result and the comparison run on every accepted sample.
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
         if (!RST_B_I) begin
            short_res[p] <= '0;
            pwr_prot <= 1'b0;
            pwr_prot_prev <= 1'b0;
         end else begin
            pwr_prot_prev <= pwr_prot;
            if (take) begin
               short_res[p] <= 13'(short_sum >> short_exp[p]);
               pwr_prot <= (long_res[p] > long_lim[p]) || (short_res[p] > short_lim[p]);
            end
         end
      end
      // The detector sees the sample as it enters, ahead of the buffered data path.
      assign POWER_PROTECT_O[p] = pwr_prot;

      // Sticky event flags; a new event in the clearing cycle keeps its flag.
      assign events[dopp_pkg::FLAG_PWR] = pwr_prot && !pwr_prot_prev;
      assign events[dopp_pkg::FLAG_LINK] = LINK_ERROR_I[p];
      assign events[dopp_pkg::FLAG_SW] = sw_trig;
      assign events[dopp_pkg::FLAG_BLANK] = blank_prot;
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
         if (!RST_B_I) begin
            flags[p] <= '0;
         end else if (paged_write(page, p, REG_ADDR_I, dopp_pkg::OFF_FLAGS) && REG_WR_I) begin
            flags[p] <= (flags[p] & ~REG_WDATA_I[3:0]) | events;
         end else begin
            flags[p] <= flags[p] | events;
         end
      end

      // Feedforward ramp request to the gain stage, gathered from all four triggers.
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
         if (!RST_B_I) begin
            RAMP_DOWN_O[p] <= 1'b1;
         end else begin
            RAMP_DOWN_O[p] <= (blank_state != dopp_pkg::DOPP_BLANK_RUN)
               || (prot_ctrl[p][dopp_pkg::CTRL_PWR_RAMP] && (pwr_prot || flags[p][dopp_pkg::FLAG_PWR]))
               || (prot_ctrl[p][dopp_pkg::CTRL_LINK_RAMP] && flags[p][dopp_pkg::FLAG_LINK])
               || flags[p][dopp_pkg::FLAG_SW];
         end
      end

      // Interrupt routing: enable in the low nibble, pin choice in the high nibble.
      assign interrupt_out_0_hit[p] = |(flags[p] & irq_cfg[p][3:0] & ~irq_cfg[p][7:4]);
      assign interrupt_out_1_hit[p] = |(flags[p] & irq_cfg[p][3:0] & irq_cfg[p][7:4]);

      // Two-entry buffer; a stalled receiver fills it and then blocks the input.
      assign push = take;
      assign pop = SAMPLE_VALID_O[p] && SAMPLE_READY_I[p];
      assign SAMPLE_READY_O[p] = (count != 2'd2) && rate_en && !blank_prot;
      assign SAMPLE_VALID_O[p] = (count != 2'd0);
      assign SAMPLE_O[p] = mem[rd_ptr];
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
         if (!RST_B_I) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
            mem[0] <= '0;
            mem[1] <= '0;
         end else if (blank_prot) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
         end else begin
            if (push) begin
               mem[wr_ptr] <= SAMPLE_I[p];
               wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
               rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
         end
      end
   end

   assign INTERRUPT_OUT_0_B_O = ~|interrupt_out_0_hit;
   assign INTERRUPT_OUT_1_B_O = ~|interrupt_out_1_hit;

   // Read data is registered one cycle after the read strobe; unmapped reads give zero.
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         REG_RDATA_O <= 8'h00;
      end else if (REG_RD_I) begin
         case (REG_ADDR_I)
            dopp_pkg::OFF_PAGE: REG_RDATA_O <= page;
            dopp_pkg::OFF_MAIN_INTERP: REG_RDATA_O <= main_interp;
            dopp_pkg::OFF_LONG_LIM_LO: REG_RDATA_O <= long_lim[read_path(page)][7:0];
            dopp_pkg::OFF_LONG_LIM_HI: REG_RDATA_O <= {3'h0, long_lim[read_path(page)][12:8]};
            dopp_pkg::OFF_LONG_EXP: REG_RDATA_O <= {4'h0, long_exp[read_path(page)]};
            dopp_pkg::OFF_LONG_RES_LO: REG_RDATA_O <= long_res[read_path(page)][7:0];
            dopp_pkg::OFF_LONG_RES_HI: REG_RDATA_O <= {3'h0, long_res[read_path(page)][12:8]};
            dopp_pkg::OFF_SHORT_LIM_LO: REG_RDATA_O <= short_lim[read_path(page)][7:0];
            dopp_pkg::OFF_SHORT_LIM_HI: REG_RDATA_O <= {3'h0, short_lim[read_path(page)][12:8]};
            dopp_pkg::OFF_SHORT_EXP: REG_RDATA_O <= {6'h00, short_exp[read_path(page)]};
            dopp_pkg::OFF_SHORT_RES_LO: REG_RDATA_O <= short_res[read_path(page)][7:0];
            dopp_pkg::OFF_SHORT_RES_HI: REG_RDATA_O <= {3'h0, short_res[read_path(page)][12:8]};
            dopp_pkg::OFF_PROT_CTRL: REG_RDATA_O <= prot_ctrl[read_path(page)];
            dopp_pkg::OFF_IRQ_CFG: REG_RDATA_O <= irq_cfg[read_path(page)];
            dopp_pkg::OFF_FLAGS: REG_RDATA_O <= {4'h0, flags[read_path(page)]};
            default: REG_RDATA_O <= 8'h00;
         endcase
      end
   end

endmodule

// ### bench/dopp_checker_properties.sv
// Concurrent checks on the ports of the output power protection block.
`timescale 1ns/1ps
module dopp_checker (
   input wire logic CLK_I,
   input wire logic RST_B_I,
   input wire logic [11:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_RDATA_O,
   input wire logic CHAN_BYPASS_I,
   input wire dopp_pkg::dopp_sample_t [1:0] SAMPLE_O,
   input wire logic [1:0] SAMPLE_VALID_I,
   input wire logic [1:0] SAMPLE_READY_O,
   input wire logic [1:0] SAMPLE_VALID_O,
   input wire logic [1:0] SAMPLE_READY_I,
   input wire logic [1:0] TRANSMIT_ENABLE_I,
   input wire logic [1:0] LINK_ERROR_I,
   input wire logic [1:0] POWER_PROTECT_O,
   input wire logic [1:0] RAMP_DOWN_O,
   input wire logic MAIN_BYPASS_O
);
   logic [2:0] te_h;
   logic [2:0] wr_h;
   logic quiet;
   default clocking dck @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   // Recent enable and write history, since either may start a flush that drops buffered words.
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         te_h <= 3'h0;
         wr_h <= 3'h0;
      end else begin
         te_h <= {te_h[1:0], TRANSMIT_ENABLE_I[0]};
         wr_h <= {wr_h[1:0], REG_WR_I};
      end
   end
   // No flush can be under way when this is high.
   assign quiet = (te_h == {3{TRANSMIT_ENABLE_I[0]}}) && (wr_h == 3'h0) && !REG_WR_I;
   sequence te_rise;
      $rose(TRANSMIT_ENABLE_I[0]);
   endsequence
   sequence capped_slot;
      !CHAN_BYPASS_I && SAMPLE_READY_O[0];
   endsequence
   unmapped_read_a: assert property (REG_RD_I && REG_ADDR_I == 12'h000 |=> REG_RDATA_O == 8'h00)
      else $error("unmapped read returned nonzero data");
   bypass_mirror_a: assert property (REG_WR_I && REG_ADDR_I == dopp_pkg::OFF_MAIN_INTERP |=>
      MAIN_BYPASS_O == ($past(REG_WDATA_I) == 8'h00)) else $error("bypass flag wrong");
   rate_cap_a: assert property (capped_slot ##1 !CHAN_BYPASS_I |-> !SAMPLE_READY_O[0])
      else $error("capped input accepted on two cycles in a row");
   blank_ramp_a: assert property (te_rise |-> ##2 RAMP_DOWN_O[0])
      else $error("enable rise did not hold ramp down");
   flush_ready_a: assert property (te_rise |-> ##[1:2] !SAMPLE_READY_O[0])
      else $error("no flush cycle after enable rise");
   link_ramp_a: assert property (LINK_ERROR_I[1] |-> ##[1:3] RAMP_DOWN_O[1])
      else $error("link error did not ramp down");
   sw_ramp_a: assert property (REG_WR_I && REG_ADDR_I == dopp_pkg::OFF_PROT_CTRL &&
      REG_WDATA_I[2] |-> ##[1:3] RAMP_DOWN_O != 2'b00) else $error("software trigger ignored");
   power_ramp_a: assert property ($rose(POWER_PROTECT_O[0]) |-> ##[0:2] RAMP_DOWN_O[0])
      else $error("power protect did not ramp down");
   protect_steady_a: assert property (!(SAMPLE_VALID_I[0] && SAMPLE_READY_O[0]) |=>
      $stable(POWER_PROTECT_O[0])) else $error("power protect moved without a sample");
   word_hold_a: assert property (SAMPLE_VALID_O[0] && !SAMPLE_READY_I[0] && quiet |=>
      SAMPLE_VALID_O[0] && $stable(SAMPLE_O[0])) else $error("stalled word not held");
   fill_valid_a: assert property (SAMPLE_VALID_I[0] && SAMPLE_READY_O[0] && !SAMPLE_VALID_O[0]
      && quiet |=> SAMPLE_VALID_O[0]) else $error("accepted word not offered");
endmodule
bind dopp_top dopp_checker i_dopp_checker (.*);

// ### bench/dopp_stream_model.sv
// Stream partner: sample source for the summing node and a stalling ramp-stage sink.
`timescale 1ns/1ps
module dopp_stream_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [15:0] budget_i,
   input wire logic [15:0] i_val_i,
   input wire logic [1:0] stall_i,
   input wire logic [1:0] dut_ready_i,
   input wire logic [1:0] dut_valid_i,
   input wire dopp_pkg::dopp_sample_t [1:0] dut_sample_i,
   output dopp_pkg::dopp_sample_t [1:0] sample_o,
   output logic [1:0] valid_o,
   output logic [1:0] ready_o,
   output logic [1:0][15:0] sent_o,
   output dopp_pkg::dopp_sample_t [1:0] last_o
);
   dopp_pkg::dopp_sample_t word;
   // Count words handed over and keep the last word taken from each path.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sent_o <= '0;
         last_o <= '0;
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (valid_o[p] && dut_ready_i[p]) sent_o[p] <= sent_o[p] + 16'h1;
            if (dut_valid_i[p] && ready_o[p]) last_o[p] <= dut_sample_i[p];
         end
      end
   end
   // Drive after the falling edge; an idle data line shows the inverted word, never a stale one.
   always @(negedge clk_i) begin
      for (int p = 0; p < 2; p++) begin
         word = {i_val_i, 6'h00, sent_o[p][9:0]};
         valid_o[p] = rst_b_i && (sent_o[p] < budget_i);
         sample_o[p] = valid_o[p] ? word : ~word;
         ready_o[p] = !stall_i[p];
      end
   end
   // Quiet outputs before the first falling edge.
   initial begin
      valid_o = 2'h0;
      ready_o = 2'h0;
      sample_o = '0;
   end
endmodule

// ### bench/test_dac_output_power_protection.sv
// Register and stream tests of the output power protection block.
`timescale 1ns/1ps
module test_dac_output_power_protection;
   logic CLK_I, RST_B_I, REG_WR_I, REG_RD_I, CHAN_BYPASS_I, MAIN_BYPASS_O;
   logic INTERRUPT_OUT_0_B_O, INTERRUPT_OUT_1_B_O;
   logic [11:0] REG_ADDR_I;
   logic [7:0] REG_WDATA_I, REG_RDATA_O;
   logic [1:0] SAMPLE_VALID_I, SAMPLE_READY_O, SAMPLE_VALID_O, SAMPLE_READY_I;
   logic [1:0] TRANSMIT_ENABLE_I, LINK_ERROR_I, POWER_PROTECT_O, RAMP_DOWN_O, stall;
   dopp_pkg::dopp_sample_t [1:0] SAMPLE_I, SAMPLE_O, last;
   logic [1:0][15:0] sent;
   logic [15:0] budget, mark;
   int num_errors = 0;
   int checks = 0;
   dopp_top i_dopp_top (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .REG_ADDR_I(REG_ADDR_I),
      .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
      .REG_RDATA_O(REG_RDATA_O), .CHAN_BYPASS_I(CHAN_BYPASS_I), .SAMPLE_I(SAMPLE_I),
      .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_READY_O(SAMPLE_READY_O), .SAMPLE_O(SAMPLE_O),
      .SAMPLE_VALID_O(SAMPLE_VALID_O), .SAMPLE_READY_I(SAMPLE_READY_I),
      .TRANSMIT_ENABLE_I(TRANSMIT_ENABLE_I), .LINK_ERROR_I(LINK_ERROR_I),
      .POWER_PROTECT_O(POWER_PROTECT_O), .RAMP_DOWN_O(RAMP_DOWN_O),
      .MAIN_BYPASS_O(MAIN_BYPASS_O), .INTERRUPT_OUT_0_B_O(INTERRUPT_OUT_0_B_O),
      .INTERRUPT_OUT_1_B_O(INTERRUPT_OUT_1_B_O));
   dopp_stream_model i_dopp_stream_model (.clk_i(CLK_I), .rst_b_i(RST_B_I), .budget_i(budget),
      .i_val_i(16'h4000), .stall_i(stall), .dut_ready_i(SAMPLE_READY_O),
      .dut_valid_i(SAMPLE_VALID_O), .dut_sample_i(SAMPLE_O), .sample_o(SAMPLE_I),
      .valid_o(SAMPLE_VALID_I), .ready_o(SAMPLE_READY_I), .sent_o(sent), .last_o(last));
   // A 40 ns clock.
   initial begin
      CLK_I = 1'b0;
      forever #20 CLK_I = ~CLK_I;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge CLK_I);
      REG_ADDR_I = a;
      REG_WDATA_I = d;
      REG_WR_I = 1'b1;
      @(negedge CLK_I);
      REG_WR_I = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
      @(negedge CLK_I);
      REG_ADDR_I = a;
      REG_RD_I = 1'b1;
      @(negedge CLK_I);
      REG_RD_I = 1'b0;
      @(negedge CLK_I);
      chk(n, 16'(e), 16'(REG_RDATA_O));
   endtask
   // Raise the source budget and wait, bounded, until path 0 has handed it all over.
   task automatic wait_sent(input logic [15:0] n);
      int k;
      budget = n;
      k = 0;
      while (sent[0] < n && k < 3000) begin
         @(negedge CLK_I);
         k++;
      end
      chk("words sent", n, sent[0]);
      repeat (4) @(negedge CLK_I);
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog: the tests need about 700 cycles.
   initial begin
      #(40 * 5000);
      num_errors++;
      $display("BAD watchdog expected finish seen timeout");
      end_of_test();
   end
   // Main sequence.
   initial begin
      {RST_B_I, REG_WR_I, REG_RD_I, REG_ADDR_I, REG_WDATA_I} = '0;
      {TRANSMIT_ENABLE_I, LINK_ERROR_I, stall, budget} = '0;
      CHAN_BYPASS_I = 1'b1;
      repeat (2) @(negedge CLK_I);
      RST_B_I = 1'b1;
      rd(12'h008, 8'hc0, "page reset");
      rd(12'h583, 8'hff, "long limit low reset");
      rd(12'h584, 8'h1f, "long limit high reset");
      rd(12'h585, 8'h00, "long exponent reset");
      rd(12'h000, 8'h00, "unmapped read");
      $display("reset values done");
      wr(12'h008, 8'h40);
      wr(12'h588, 8'h12);
      wr(12'h008, 8'h80);
      rd(12'h588, 8'hff, "path 1 limit untouched");
      wr(12'h008, 8'h40);
      rd(12'h588, 8'h12, "path 0 limit");
      wr(12'h008, 8'hc0);
      wr(12'h58a, 8'h01);
      rd(12'h58a, 8'h01, "both paged path 0");
      wr(12'h008, 8'h80);
      rd(12'h58a, 8'h01, "both paged path 1");
      wr(12'h008, 8'hc0);
      wr(12'h58a, 8'h00);
      wr(12'h008, 8'h00);
      wr(12'h589, 8'h00);
      wr(12'h008, 8'h80);
      rd(12'h589, 8'h1f, "unpaged write ignored");
      wr(12'h110, 8'h02);
      chk("main bypass off", 16'h0, 16'(MAIN_BYPASS_O));
      wr(12'h110, 8'h00);
      chk("main bypass on", 16'h1, 16'(MAIN_BYPASS_O));
      $display("paging done");
      wr(12'h590, 8'h0b);
      TRANSMIT_ENABLE_I = 2'b01;
      repeat (5) @(negedge CLK_I);
      chk("ramp released", 16'h0, 16'(RAMP_DOWN_O));
      wr(12'h008, 8'h40);
      rd(12'h592, 8'h08, "blank flag");
      wr(12'h008, 8'hc0);
      wr(12'h592, 8'h0f);
      wr(12'h008, 8'h40);
      wr(12'h588, 8'hff);
      wr(12'h589, 8'h00);
      wr(12'h591, 8'h01);
      wait_sent(16'd20);
      chk("short protect", 16'h1, 16'(POWER_PROTECT_O));
      chk("power ramp", 16'h1, 16'(RAMP_DOWN_O));
      chk("irq route 0", 16'h2, 16'({INTERRUPT_OUT_1_B_O, INTERRUPT_OUT_0_B_O}));
      rd(12'h58b, 8'h00, "short result low");
      rd(12'h58c, 8'h01, "short result high");
      wr(12'h591, 8'h11);
      chk("irq route 1", 16'h1, 16'({INTERRUPT_OUT_1_B_O, INTERRUPT_OUT_0_B_O}));
      $display("short power done");
      wr(12'h008, 8'h80);
      wr(12'h583, 8'hff);
      wr(12'h584, 8'h00);
      wait_sent(16'd512);
      wr(12'h008, 8'h40);
      rd(12'h586, 8'h00, "long result low");
      rd(12'h587, 8'h01, "long result high");
      wait_sent(16'd513);
      chk("long protect", 16'h3, 16'(POWER_PROTECT_O));
      $display("long power done");
      @(negedge CLK_I);
      LINK_ERROR_I = 2'b10;
      @(negedge CLK_I);
      LINK_ERROR_I = 2'b00;
      wr(12'h008, 8'h80);
      rd(12'h592, 8'h03, "link flag");
      wr(12'h008, 8'h40);
      wr(12'h590, 8'h07);
      rd(12'h592, 8'h05, "software flag");
      rd(12'h590, 8'h03, "trigger reads zero");
      $display("triggers done");
      stall = 2'b11;
      budget = 16'd518;
      repeat (8) @(negedge CLK_I);
      chk("buffer fill", 16'd515, sent[0]);
      chk("buffer full", 16'h0, 16'(SAMPLE_READY_O));
      stall = 2'b00;
      repeat (12) @(negedge CLK_I);
      chk("drain order", 16'h0205, 16'(last[0].q));
      chk("drained", 16'h0, 16'(SAMPLE_VALID_O));
      $display("buffer done");
      CHAN_BYPASS_I = 1'b0;
      budget = 16'd600;
      @(negedge CLK_I);
      mark = sent[0];
      repeat (20) @(negedge CLK_I);
      chk("capped rate", 16'd10, sent[0] - mark);
      CHAN_BYPASS_I = 1'b1;
      $display("rate cap done");
      end_of_test();
   end
endmodule
